//--- inc/ddrpl_pkg.sv
// Constants and carrier types of the controller-facing read-latency port.
package ddrpl_pkg;
   // Data path shape.
   localparam int DATA_WIDTH_RATIO = 4;
   localparam int MEMORY_DATA_WIDTH = 8;
   localparam int HALVES = DATA_WIDTH_RATIO / 2;
   localparam int RDATA_W = DATA_WIDTH_RATIO * MEMORY_DATA_WIDTH;
   localparam int ROW_W = 14;
   localparam int BANK_W = 3;
   localparam int CS_W = 1;
   localparam int LAT_W = 5;
   localparam int DELAY_DEPTH = 32;
   localparam int FIFO_DEPTH = 2;
   localparam logic [LAT_W-1:0] PIPE_STAGES = 5'h02;
   localparam logic [1:0] FIFO_FULL_CNT = 2'h2;
   ////////////////////////////////////////////////////////////////////////////////
   // Register map, byte addresses on APB.
   localparam int ADDR_W = 8;
   localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_WLAT = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_RLAT = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h0c;
   // Field positions.
   localparam int CTRL_CAL_DONE_BIT = 0;
   localparam int STAT_CNT_W = 16;
   localparam int STAT_OVR_BIT = 16;
   localparam int STAT_FULL_BIT = 17;
   // Reset values.
   localparam logic [LAT_W-1:0] WLAT_RST = 5'h00;
   localparam logic [LAT_W-1:0] RLAT_RST = 5'h02;
   localparam logic [STAT_CNT_W-1:0] CNT_RST = 16'h0000;
   ////////////////////////////////////////////////////////////////////////////////
   // Address and command slots from the controller.
   typedef struct packed {
      logic [ROW_W*HALVES-1:0] addr;
      logic [BANK_W*HALVES-1:0] ba;
      logic [CS_W*HALVES-1:0] cke;
      logic [CS_W-1:0] cs_n;
      logic [CS_W*HALVES-1:0] odt;
      logic [HALVES-1:0] ras_n;
   } ddrpl_cmd_t;
   // One captured read word with its per-half valid flags.
   typedef struct packed {
      logic [HALVES-1:0] valid;
      logic [RDATA_W-1:0] data;
   } ddrpl_rd_t;
endpackage : ddrpl_pkg

//--- hw/ddrpl_top.sv
// Controller-facing latency report, read capture and command port of the PHY.
`timescale 1ns/1ps
`default_nettype none
module ddrpl_top (
   input wire logic CLK_SYS,
   input wire logic RESET,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [ddrpl_pkg::ADDR_W-1:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   output logic CTL_CLK,
   output logic CTL_RESET_N,
   output logic [ddrpl_pkg::LAT_W-1:0] CTL_WLAT,
   output logic [ddrpl_pkg::LAT_W-1:0] CTL_RLAT,
   output logic CTL_CAL_SUCCESS,
   input wire logic [ddrpl_pkg::HALVES-1:0] CTL_DOING_RD,
   input wire ddrpl_pkg::ddrpl_cmd_t CTL_CMD,
   output logic [ddrpl_pkg::RDATA_W-1:0] CTL_RDATA,
   output logic [ddrpl_pkg::HALVES-1:0] CTL_RDATA_VALID,
   input wire logic CTL_RDATA_READY,
   input wire logic [ddrpl_pkg::RDATA_W-1:0] CAP_RDATA,
   output logic CAP_READY,
   output ddrpl_pkg::ddrpl_cmd_t MEM_CMD
);

   ////////////////////////////////////////////////////////////////////////////////
   // Declarations.
   logic cal_done;
   logic next_cal_done;
   logic [ddrpl_pkg::LAT_W-1:0] wlat;
   logic [ddrpl_pkg::LAT_W-1:0] next_wlat;
   logic [ddrpl_pkg::LAT_W-1:0] rlat;
   logic [ddrpl_pkg::LAT_W-1:0] next_rlat;
   logic ovr;
   logic next_ovr;
   logic [ddrpl_pkg::STAT_CNT_W-1:0] rd_cnt;
   logic [ddrpl_pkg::STAT_CNT_W-1:0] next_rd_cnt;
   logic [31:0] prdata;
   logic [31:0] next_prdata;
   logic wr_en;
   logic setup_rd;
   logic mapped;
   logic [ddrpl_pkg::HALVES-1:0] dly [ddrpl_pkg::DELAY_DEPTH];
   logic [ddrpl_pkg::HALVES-1:0] next_dly [ddrpl_pkg::DELAY_DEPTH];
   logic [ddrpl_pkg::LAT_W-1:0] tap;
   logic [ddrpl_pkg::HALVES-1:0] cap_en;
   logic cap_vld;
   logic next_cap_vld;
   ddrpl_pkg::ddrpl_rd_t cap;
   ddrpl_pkg::ddrpl_rd_t next_cap;
   logic lost;
   ddrpl_pkg::ddrpl_rd_t mem [ddrpl_pkg::FIFO_DEPTH];
   ddrpl_pkg::ddrpl_rd_t next_mem [ddrpl_pkg::FIFO_DEPTH];
   logic wp;
   logic next_wp;
   logic rp;
   logic next_rp;
   logic [1:0] cnt;
   logic [1:0] next_cnt;
   logic room;
   logic push;
   logic pop;
   logic [1:0] rst_sync;
   logic [1:0] next_rst_sync;
   ddrpl_pkg::ddrpl_cmd_t cmd;
   ddrpl_pkg::ddrpl_cmd_t next_cmd;

   ////////////////////////////////////////////////////////////////////////////////
   // Controller clock and reset in that clock's domain.

   // The controller runs straight on the system clock, so no edge is shifted.
   assign CTL_CLK = CLK_SYS;

   // Assert at once, release two edges later so the controller leaves reset cleanly.
   always_comb begin
      next_rst_sync = {rst_sync[0], 1'b1};
   end

   always_ff @(posedge CLK_SYS or posedge RESET) begin
      if (RESET) begin
         rst_sync <= 2'h0;
      end else begin
         rst_sync <= next_rst_sync;
      end
   end

   assign CTL_RESET_N = rst_sync[1];

   ////////////////////////////////////////////////////////////////////////////////
   // APB slave and register file.

   // Zero wait states; unmapped offsets answer with an error and read zero.
   assign wr_en = PSEL & PENABLE & PWRITE;
   assign setup_rd = PSEL & ~PENABLE & ~PWRITE;
   assign mapped = (PADDR == ddrpl_pkg::OFS_CTRL) | (PADDR == ddrpl_pkg::OFS_WLAT) |
                   (PADDR == ddrpl_pkg::OFS_RLAT) | (PADDR == ddrpl_pkg::OFS_STATUS);
   assign PREADY = 1'b1;
   assign PSLVERR = PSEL & PENABLE & ~mapped;
   assign PRDATA = prdata;

   // Latency registers lock once calibration is flagged, so the controller can
   // trust them for the whole of normal operation; only a reset unlocks them.
   always_comb begin
      next_cal_done = cal_done;
      next_wlat = wlat;
      next_rlat = rlat;
      next_ovr = ovr;
      next_prdata = prdata;
      next_rd_cnt = rd_cnt;
      if (|CTL_DOING_RD) begin
         next_rd_cnt = rd_cnt + 16'h0001;
      end
      if (wr_en) begin
         case (PADDR)
            ddrpl_pkg::OFS_CTRL: begin
               if (PWDATA[ddrpl_pkg::CTRL_CAL_DONE_BIT]) begin
                  next_cal_done = 1'b1;
               end
            end
            ddrpl_pkg::OFS_WLAT: begin
               if (!cal_done) begin
                  next_wlat = PWDATA[ddrpl_pkg::LAT_W-1:0];
               end
            end
            ddrpl_pkg::OFS_RLAT: begin
               if (!cal_done) begin
                  // Below the pipeline depth the latency cannot be met; clamp.
                  if (PWDATA[ddrpl_pkg::LAT_W-1:0] < ddrpl_pkg::PIPE_STAGES) begin
                     next_rlat = ddrpl_pkg::PIPE_STAGES;
                  end else begin
                     next_rlat = PWDATA[ddrpl_pkg::LAT_W-1:0];
                  end
               end
            end
            ddrpl_pkg::OFS_STATUS: begin
               if (PWDATA[ddrpl_pkg::STAT_OVR_BIT]) begin
                  next_ovr = 1'b0;
               end
            end
            default: begin
               next_ovr = ovr;
            end
         endcase
      end
      // A loss in the clearing cycle still sets the flag.
      if (lost) begin
         next_ovr = 1'b1;
      end
      if (setup_rd) begin
         next_prdata = 32'h0000_0000;
         case (PADDR)
            ddrpl_pkg::OFS_CTRL: next_prdata[ddrpl_pkg::CTRL_CAL_DONE_BIT] = cal_done;
            ddrpl_pkg::OFS_WLAT: next_prdata[ddrpl_pkg::LAT_W-1:0] = wlat;
            ddrpl_pkg::OFS_RLAT: next_prdata[ddrpl_pkg::LAT_W-1:0] = rlat;
            ddrpl_pkg::OFS_STATUS: begin
               next_prdata[ddrpl_pkg::STAT_CNT_W-1:0] = rd_cnt;
               next_prdata[ddrpl_pkg::STAT_OVR_BIT] = ovr;
               next_prdata[ddrpl_pkg::STAT_FULL_BIT] = ~room;
            end
            default: next_prdata = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge CLK_SYS or posedge RESET) begin
      if (RESET) begin
         cal_done <= 1'b0;
         wlat <= ddrpl_pkg::WLAT_RST;
         rlat <= ddrpl_pkg::RLAT_RST;
         ovr <= 1'b0;
         rd_cnt <= ddrpl_pkg::CNT_RST;
         prdata <= 32'h0000_0000;
      end else begin
         cal_done <= next_cal_done;
         wlat <= next_wlat;
         rlat <= next_rlat;
         ovr <= next_ovr;
         rd_cnt <= next_rd_cnt;
         prdata <= next_prdata;
      end
   end

   // Both latencies come straight from their flops.
   assign CTL_WLAT = wlat;
   assign CTL_RLAT = rlat;
   assign CTL_CAL_SUCCESS = cal_done;

   ////////////////////////////////////////////////////////////////////////////////
   // Marker delay line and capture register.

   // Capture plus the buffer take two cycles, so the tap sits that much earlier.
   assign tap = rlat - ddrpl_pkg::PIPE_STAGES;
   assign cap_en = (tap == 5'h00) ? CTL_DOING_RD : dly[tap - 5'h01];

   always_comb begin
      next_dly[0] = CTL_DOING_RD;
      for (int i = 1; i < ddrpl_pkg::DELAY_DEPTH; i++) begin
         next_dly[i] = dly[i-1];
      end
   end

   always_ff @(posedge CLK_SYS or posedge RESET) begin
      if (RESET) begin
         for (int i = 0; i < ddrpl_pkg::DELAY_DEPTH; i++) begin
            dly[i] <= '0;
         end
      end else begin
         dly <= next_dly;
      end
   end

   // A held word that the full buffer cannot take blocks a new capture; the newcomer is dropped and flagged,
   // since the memory returns data on a fixed schedule and cannot wait.
   assign push = cap_vld & room;
   assign lost = (|cap_en) & cap_vld & ~push;

   always_comb begin
      next_cap_vld = cap_vld;
      next_cap = cap;
      if ((|cap_en) && (!cap_vld || push)) begin
         next_cap_vld = 1'b1;
         next_cap.valid = cap_en;
         next_cap.data = CAP_RDATA;
      end else if (push) begin
         next_cap_vld = 1'b0;
      end
   end

   always_ff @(posedge CLK_SYS or posedge RESET) begin
      if (RESET) begin
         cap_vld <= 1'b0;
         cap <= '0;
      end else begin
         cap_vld <= next_cap_vld;
         cap <= next_cap;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Two-entry read buffer toward the controller.

   assign room = (cnt != ddrpl_pkg::FIFO_FULL_CNT);
   assign pop = (cnt != 2'h0) & CTL_RDATA_READY;
   assign CAP_READY = room;

   always_comb begin
      next_mem = mem;
      next_wp = wp;
      next_rp = rp;
      next_cnt = cnt;
      if (push) begin
         next_mem[wp] = cap;
         next_wp = ~wp;
      end
      if (pop) begin
         next_rp = ~rp;
      end
      case ({push, pop})
         2'b10: next_cnt = cnt + 2'h1;
         2'b01: next_cnt = cnt - 2'h1;
         default: next_cnt = cnt;
      endcase
   end

   always_ff @(posedge CLK_SYS or posedge RESET) begin
      if (RESET) begin
         mem[0] <= '0;
         mem[1] <= '0;
         wp <= 1'b0;
         rp <= 1'b0;
         cnt <= 2'h0;
      end else begin
         mem <= next_mem;
         wp <= next_wp;
         rp <= next_rp;
         cnt <= next_cnt;
      end
   end

   // Flags are gated by occupancy so a stale slot never shows as valid.
   assign CTL_RDATA = mem[rp].data;
   assign CTL_RDATA_VALID = (cnt != 2'h0) ? mem[rp].valid : '0;

   ////////////////////////////////////////////////////////////////////////////////
   // Command slots, registered once toward the memory side.

   // Field widths follow the per-slot and per-line shape of the struct.
   always_comb begin
      next_cmd = CTL_CMD;
   end

   always_ff @(posedge CLK_SYS or posedge RESET) begin
      if (RESET) begin
         cmd <= '0;
      end else begin
         cmd <= next_cmd;
      end
   end

   assign MEM_CMD = cmd;

endmodule : ddrpl_top
`default_nettype wire

//--- tb/ddrpl_assertions.sv
// Checker on the controller-side ports of the latency and read port.
`timescale 1ns/1ps
`default_nettype none
module ddrpl_assertions (
   input wire logic CLK_SYS,
   input wire logic RESET,
   input wire logic [4:0] CTL_WLAT,
   input wire logic [4:0] CTL_RLAT,
   input wire logic CTL_CAL_SUCCESS,
   input wire logic CTL_RESET_N,
   input wire logic [1:0] CTL_DOING_RD,
   input wire ddrpl_pkg::ddrpl_cmd_t CTL_CMD,
   input wire logic [31:0] CTL_RDATA,
   input wire logic [1:0] CTL_RDATA_VALID,
   input wire logic CTL_RDATA_READY,
   input wire ddrpl_pkg::ddrpl_cmd_t MEM_CMD
);
   // All checks live in the one clock domain and sleep through reset.
   default clocking @(posedge CLK_SYS); endclocking
   default disable iff (RESET);
   ////////////////////////////////////////////////////////////////////////////////
   // Latencies and the calibration flag are frozen once calibration is done.
   a_wlat_frozen:
      assert property (CTL_CAL_SUCCESS |=> $stable(CTL_WLAT)) else $error("wlat moved");
   a_rlat_frozen:
      assert property (CTL_CAL_SUCCESS |=> $stable(CTL_RLAT)) else $error("rlat moved");
   a_cal_sticky:
      assert property (CTL_CAL_SUCCESS |=> CTL_CAL_SUCCESS) else $error("cal flag fell");
   a_rlat_floor:
      assert property (CTL_RLAT >= 5'h02) else $error("rlat below pipeline depth");
   // A marker returns its flags after a reported latency of two when nothing stalls.
   a_valid_time:
      assert property ((CTL_DOING_RD != 2'h0 && CTL_RLAT == 5'h02 && CTL_RDATA_READY)
         ##1 CTL_RDATA_READY [*2] |-> CTL_RDATA_VALID == $past(CTL_DOING_RD, 2))
      else $error("read beat late or wrong");
   a_valid_hold:
      assert property (CTL_RDATA_VALID != 2'h0 && !CTL_RDATA_READY |=>
         $stable(CTL_RDATA_VALID) && $stable(CTL_RDATA))
      else $error("held read beat changed");
   a_cmd_pass:
      assert property (!$past(RESET) |-> MEM_CMD == $past(CTL_CMD)) else $error("cmd lost");
   a_reset_out:
      assert property ($past(RESET) |-> !CTL_RESET_N ##[1:2] CTL_RESET_N)
      else $error("controller reset release wrong");
endmodule : ddrpl_assertions
`default_nettype wire
bind ddrpl_top ddrpl_assertions ddrpl_assertions_i (.CLK_SYS(CLK_SYS), .RESET(RESET),
   .CTL_WLAT(CTL_WLAT), .CTL_RLAT(CTL_RLAT), .CTL_CAL_SUCCESS(CTL_CAL_SUCCESS),
   .CTL_RESET_N(CTL_RESET_N), .CTL_DOING_RD(CTL_DOING_RD), .CTL_CMD(CTL_CMD),
   .CTL_RDATA(CTL_RDATA), .CTL_RDATA_VALID(CTL_RDATA_VALID),
   .CTL_RDATA_READY(CTL_RDATA_READY), .MEM_CMD(MEM_CMD));

//--- tb/ddrpl_ctl_model.sv
// Memory controller model: read markers, command slots and read accept.
`timescale 1ns/1ps
`default_nettype none
module ddrpl_ctl_model (
   input wire logic clk,
   input wire logic rst,
   input wire logic [1:0] rd_req,
   input wire logic stall,
   input wire logic [31:0] noise,
   output logic [1:0] doing_rd,
   output ddrpl_pkg::ddrpl_cmd_t cmd,
   output logic ready
);
   // One marker cycle per read, sent with its command; idle slots churn noise.
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         doing_rd <= 2'h0;
         cmd <= '1;
         ready <= 1'b0;
      end else begin
         doing_rd <= rd_req;
         // Chip select sits just above the two termination slots and the strobes.
         cmd <= {noise[8:0], noise[31:5], rd_req == 2'h0, noise[3:0]};
         ready <= !stall;
      end
   end
endmodule : ddrpl_ctl_model
`default_nettype wire

//--- tb/test_dram_phy_latency_read_port.sv
// Self-checking bench for the controller-facing latency and read port.
`timescale 1ns/1ps
`default_nettype none
module test_dram_phy_latency_read_port;
   logic clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, stall = 0, pslverr, pready, e;
   logic cal, rready, capr, ctl_clk;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rdata, r, rnd = 32'h13e577f7, cap = 32'h13e577f7;
   logic [4:0] wlat, rlat;
   logic [4:0] vals[5] = '{5'h00, 5'h01, 5'h1f, 5'h0a, 5'h02};
   logic [1:0] req = 2'h0, doing, rvalid;
   ddrpl_pkg::ddrpl_cmd_t cmd;
   logic [39:0] q[$];
   int miscompares = 0, checks_done = 0, n;
   int ctl_ticks = 0, sys_ticks = 0, marks = 0;
   ////////////////////////////////////////////////////////////////////////////////
   // Clock, design and controller model.
   always #20 clk = ~clk;
   ddrpl_top ddrpl_top_i (.CLK_SYS(clk), .RESET(rst), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr),
      .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
      .CTL_CLK(ctl_clk), .CTL_RESET_N(), .CTL_WLAT(wlat), .CTL_RLAT(rlat), .CTL_CAL_SUCCESS(cal),
      .CTL_DOING_RD(doing), .CTL_CMD(cmd), .CTL_RDATA(rdata), .CTL_RDATA_VALID(rvalid),
      .CTL_RDATA_READY(rready), .CAP_RDATA(cap), .CAP_READY(capr), .MEM_CMD());
   ddrpl_ctl_model ddrpl_ctl_model_i (.clk(clk), .rst(rst), .rd_req(req), .stall(stall),
      .noise(cap), .doing_rd(doing), .cmd(cmd), .ready(rready));
   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] xs(input logic [31:0] v);
      logic [31:0] x;
      x = v ^ (v << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction : xs
   // Stored read latency never drops below the capture pipeline depth.
   function automatic logic [4:0] exp_rlat(input logic [4:0] v);
      return (v < 5'h02) ? 5'h02 : v;
   endfunction : exp_rlat
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : wrap_up
   task automatic chk(input logic [39:0] got, input logic [39:0] exp);
      checks_done++;
      if (got !== exp) begin
         miscompares++;
         $display("MISMATCH %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   // One APB transfer; an idle cycle follows so no strobe is set twice in a step.
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      pen <= 1'b1;
      for (n = 0; n < 16; n++) begin
         @(posedge clk);
         if (pready === 1'b1) break;
      end
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      pen <= 1'b0;
      if (n == 16) begin
         miscompares++;
         wrap_up();
      end
      @(posedge clk);
   endtask : apb
   ////////////////////////////////////////////////////////////////////////////////
   // Capture word changes every cycle, so a late or early sample shows up.
   always @(posedge clk) cap <= xs(cap);
   // The controller clock must tick edge for edge with the system clock.
   always @(posedge clk) sys_ticks++;
   always @(posedge ctl_clk) ctl_ticks++;
   // Scoreboard seen at mid-cycle, where both sides have settled.
   always @(negedge clk) if (!rst) begin
      if (rvalid != 2'h0 && rready === 1'b1) begin
         chk(40'(q.size() != 0), 40'h1);
         if (q.size() != 0) chk({6'h0, rvalid, rdata}, q.pop_front());
      end
      if (doing != 2'h0) begin
         q.push_back({6'h0, doing, cap});
         marks++;
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      repeat (2) @(posedge clk);
      apb(1'b0, ddrpl_pkg::OFS_RLAT, 32'h0);
      chk(40'(r), 40'(ddrpl_pkg::RLAT_RST));
      apb(1'b0, ddrpl_pkg::OFS_WLAT, 32'h0);
      chk(40'(r), 40'(ddrpl_pkg::WLAT_RST));
      // Latency values at both ends of the range and a random one.
      for (int i = 0; i < 5; i++) begin
         rnd = xs(rnd);
         if (i == 3) vals[3] = rnd[4:0];
         apb(1'b1, ddrpl_pkg::OFS_WLAT, 32'(vals[i]));
         chk(40'(wlat), 40'(vals[i]));
         apb(1'b1, ddrpl_pkg::OFS_RLAT, 32'(vals[i]));
         apb(1'b0, ddrpl_pkg::OFS_RLAT, 32'h0);
         chk({r[7:0], 27'h0, rlat}, {3'h0, exp_rlat(vals[i]), 27'h0, exp_rlat(vals[i])});
      end
      apb(1'b0, 8'h10, 32'h0);
      chk({39'h0, e}, 40'h1);
      // Issuing only while the queue is empty caps outstanding reads at two.
      for (int i = 0; i < 400; i++) begin
         rnd = xs(rnd);
         stall <= rnd[5] & rnd[6];
         req <= (q.size() == 0) ? rnd[1:0] : 2'h0;
         @(posedge clk);
      end
      req <= 2'h0;
      stall <= 1'b1;
      for (n = 0; n < 8 && q.size() < 2; n++) begin
         @(posedge clk);
         req <= 2'(n + 1);
         @(posedge clk);
         req <= 2'h0;
         repeat (4) @(posedge clk);
      end
      @(negedge clk);
      chk({39'h0, capr}, 40'h0);
      chk(40'(ctl_ticks), 40'(sys_ticks));
      @(posedge clk);
      apb(1'b0, ddrpl_pkg::OFS_STATUS, 32'h0);
      chk(40'(r[ddrpl_pkg::STAT_FULL_BIT]), 40'h1);
      chk(40'(r[ddrpl_pkg::STAT_CNT_W-1:0]), 40'(marks[15:0]));
      chk(40'(r[ddrpl_pkg::STAT_OVR_BIT]), 40'h0);
      stall <= 1'b0;
      for (n = 0; n < 20 && q.size() != 0; n++) @(posedge clk);
      chk(40'(q.size()), 40'h0);
      apb(1'b1, ddrpl_pkg::OFS_CTRL, 32'h1);
      chk(40'(cal), 40'h1);
      apb(1'b1, ddrpl_pkg::OFS_WLAT, 32'h1d);
      chk(40'(wlat), 40'(vals[4]));
      wrap_up();
   end
endmodule : test_dram_phy_latency_read_port
`default_nettype wire
